// File: rtl/deadband_pkg.sv
// Shared constants, types and helpers of the dead-band generator stage
package deadband_pkg;

    // Port and field widths
    localparam int ADDR_W = 8;              // Register port address width
    localparam int DATA_W = 16;             // Register port data width
    localparam int CNT_W  = 10;             // Delay count width
    localparam int DIV_W  = 8;              // Tick divider width

    // Register offsets on the plain port
    localparam logic [7:0] OFS_CTRL    = 8'h1e; // deadband_control
    localparam logic [7:0] OFS_RED     = 8'h20; // rising_delay_count
    localparam logic [7:0] OFS_FED     = 8'h22; // falling_delay_count
    localparam logic [7:0] OFS_TICKDIV = 8'h50; // Tick divider setting
    localparam logic [7:0] OFS_STATUS  = 8'h52; // Live stage status

    // Field positions in deadband_control
    localparam int CTRL_OUT_LSB = 0;        // S1,S0 delay-apply select
    localparam int CTRL_POL_LSB = 2;        // S3,S2 polarity_select
    localparam int CTRL_IN_LSB  = 4;        // Delay-source select
    localparam int CTRL_W       = 6;        // Implemented control bits

    // Bit positions in the status word
    localparam int STAT_OUT_A    = 0;       // Current pwm_out_a
    localparam int STAT_OUT_B    = 1;       // Current pwm_out_b
    localparam int STAT_RED_BUSY = 2;       // Rising delay counting
    localparam int STAT_FED_BUSY = 3;       // Falling delay counting

    // Reset values
    localparam logic [1:0] MODE_RST = 2'h0;       // Each control field
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000; // Delay counts
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;   // Tick every clock

    // Control fields, laid out as in the register word
    typedef struct packed {
        logic [1:0] in_mode;                // Bit0 rising, bit1 falling
        logic [1:0] pol;                    // {S3,S2}
        logic [1:0] out_mode;               // {S1,S0}
    } deadband_ctrl_t;

    // Delay path state
    typedef enum logic [1:0] {
        ST_OFF,                             // Delayed edge not seen yet
        ST_WAIT,                            // Counting ticks
        ST_ON                               // Delayed level asserted
    } dly_state_t;

    // Delay source pick, used once per delay path
    function automatic logic pick_src(input logic use_b,
                                      input logic a,
                                      input logic b);
        return use_b ? b : a;
    endfunction : pick_src

endpackage : deadband_pkg

// File: rtl/tick_divider.sv
// Prescaler that makes the time-base tick enable from the system clock
`timescale 1ns/1ps
module tick_divider
    import deadband_pkg::*;
(
    input  wire logic             clk_sys,  // System clock
    input  wire logic             sys_rst,  // Async reset, active high
    input  wire logic [DIV_W-1:0] div,      // Tick every div+1 clocks
    output logic                  tick      // One-cycle tick enable
);

    logic [DIV_W-1:0] cnt_r;                // Clocks since last tick

    // Wrap at div; a lowered div wraps at once instead of rolling over
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= DIV_RST;
            tick  <= 1'b0;
        end else if (cnt_r >= div) begin
            cnt_r <= DIV_RST;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            tick  <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Divide by two holds one idle clock between ticks
    sequence s_div1_hold;
        (tick && div == 8'h01) ##1 (div == 8'h01);
    endsequence
    a_tick_spacing: assert property (
        s_div1_hold |-> !tick ##1 tick)
        else $error("tick spacing wrong for divide by two");

endmodule : tick_divider

// File: rtl/edge_delay.sv
// One delay path: holds back one edge type by a count of ticks
`timescale 1ns/1ps
module edge_delay
    import deadband_pkg::*;
#(
    parameter bit RISE = 1'b1               // 1 delays rising, 0 falling
)(
    input  wire logic             clk_sys,  // System clock
    input  wire logic             sys_rst,  // Async reset, active high
    input  wire logic             tick,     // Time-base tick enable
    input  wire logic             din,      // Selected source signal
    input  wire logic [CNT_W-1:0] count,    // Delay in ticks
    output logic                  dout,     // Delayed signal
    output logic                  busy      // Delay is counting
);

    dly_state_t       state_r;              // Path state
    logic [CNT_W-1:0] cnt_r;                // Ticks seen since the edge
    logic             lvl;                  // Level whose start is delayed
    logic [CNT_W:0]   cnt_inc;              // Next tick count, one wider

    assign lvl     = RISE ? din : ~din;
    assign cnt_inc = {1'b0, cnt_r} + 11'h001;
    assign dout    = RISE ? (state_r == ST_ON) : (state_r != ST_ON);
    assign busy    = (state_r == ST_WAIT);

    // Delayed edge waits for count ticks, the other edge goes through
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_OFF;
        end else begin
            case (state_r)
                ST_OFF: begin
                    if (lvl) begin          // Zero count means no delay
                        state_r <= (count == CNT_RST) ? ST_ON : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!lvl) begin         // Edge withdrawn, drop it
                        state_r <= ST_OFF;
                    end else if ({1'b0, cnt_r} >= {1'b0, count} ||
                                 (tick && cnt_inc >= {1'b0, count})) begin
                        state_r <= ST_ON;
                    end
                end
                ST_ON: begin
                    if (!lvl) begin         // Opposite edge, no delay
                        state_r <= ST_OFF;
                    end
                end
                default: state_r <= ST_OFF;
            endcase
        end
    end

    // Tick counter, only alive while waiting
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= CNT_RST;
        end else if (state_r != ST_WAIT) begin
            cnt_r <= CNT_RST;
        end else if (tick) begin
            cnt_r <= cnt_inc[CNT_W-1:0];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_opposite_pass: assert property (
        !lvl |=> state_r == ST_OFF && dout == !RISE)
        else $error("opposite edge was delayed");
    a_tick_gate: assert property (
        (state_r == ST_WAIT && lvl && !tick && cnt_r < count)
        |=> state_r == ST_WAIT)
        else $error("delayed edge left early");

endmodule : edge_delay

// File: rtl/pwm_deadband_generator.sv
// Dead-band generator stage with its register port
`timescale 1ns/1ps
//
// Functional notes
// - Output pair A and B from qualifier
// - Only qualifier A and B feed delays
// - Source select zero: A feeds both
// - Other sources: swap, split, or B both
// - Apply select picks which delays act
// - Polarity inverts each delayed path separately
// - Apply select zero bypasses, polarity ignored
// - Both applied: four classical polarity pairs
// - Select 0,1: A through, B falling-delayed
// - Select 1,0: A rising-delayed, B through
// - Every field combination is legal
// - Separate ten-bit rising and falling counts
// - Delay equals count times tick period
//
module pwm_deadband_generator
    import deadband_pkg::*;
(
    input  wire logic              clk_sys,   // System clock, 20 MHz
    input  wire logic              sys_rst,   // Async reset, active high
    input  wire logic              pwm_in_a,  // Qualifier signal A
    input  wire logic              pwm_in_b,  // Qualifier signal B
    input  wire logic [ADDR_W-1:0] reg_addr,  // Register offset
    input  wire logic [DATA_W-1:0] reg_wdata, // Write data
    input  wire logic              reg_wr,    // Write strobe
    input  wire logic              reg_rd,    // Read strobe
    output logic      [DATA_W-1:0] reg_rdata, // Read data, next cycle
    output logic                   pwm_out_a, // Stage output A
    output logic                   pwm_out_b  // Stage output B
);

    // Software state
    deadband_ctrl_t   ctrl_r;                 // deadband_control
    logic [CNT_W-1:0] red_count_r;            // rising_delay_count
    logic [CNT_W-1:0] fed_count_r;            // falling_delay_count
    logic [DIV_W-1:0] tick_div_r;             // Tick divider setting

    // Signal path
    logic             in_a_d_r;               // A aligned to delay paths
    logic             in_b_d_r;               // B aligned to delay paths
    logic             red_src;                // Rising delay source
    logic             fed_src;                // Falling delay source
    logic             red_y;                  // Rising-delayed signal
    logic             fed_y;                  // Falling-delayed signal
    logic             red_busy;               // Rising delay counting
    logic             fed_busy;               // Falling delay counting
    logic             timebase_tick;          // Prescaled tick enable
    logic             out_a_nxt;              // Next pwm_out_a
    logic             out_b_nxt;              // Next pwm_out_b

    // Field views
    logic             sel_a;                  // S1: rising path to A
    logic             sel_b;                  // S0: falling path to B
    logic             pol_a;                  // S2: invert rising path
    logic             pol_b;                  // S3: invert falling path

    // Read side
    logic [DATA_W-1:0] rd_nxt;                // Word for next cycle
    logic [DATA_W-1:0] ctrl_word;             // Control as read back
    logic [DATA_W-1:0] stat_word;             // Status as read back
    logic [CNT_W-1:0]  wdata_cnt;             // Count part of write data

    assign sel_a     = ctrl_r.out_mode[1];
    assign sel_b     = ctrl_r.out_mode[0];
    assign pol_a     = ctrl_r.pol[0];
    assign pol_b     = ctrl_r.pol[1];
    assign wdata_cnt = reg_wdata[CNT_W-1:0];

    // Control register; bits above the fields are dropped on write
    // No shadow copy: a new word acts at once
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= '{in_mode: MODE_RST, pol: MODE_RST,
                        out_mode: MODE_RST};
        end else if (reg_wr && reg_addr == OFS_CTRL) begin
            ctrl_r.in_mode  <= reg_wdata[CTRL_IN_LSB +: 2];
            ctrl_r.pol      <= reg_wdata[CTRL_POL_LSB +: 2];
            ctrl_r.out_mode <= reg_wdata[CTRL_OUT_LSB +: 2];
        end
    end

    // Rising delay count, ten bits
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            red_count_r <= CNT_RST;
        end else if (reg_wr && reg_addr == OFS_RED) begin
            red_count_r <= wdata_cnt;
        end
    end

    // Falling delay count, ten bits
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fed_count_r <= CNT_RST;
        end else if (reg_wr && reg_addr == OFS_FED) begin
            fed_count_r <= wdata_cnt;
        end
    end

    // Tick divider; zero keeps the tick at the system clock rate
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tick_div_r <= DIV_RST;
        end else if (reg_wr && reg_addr == OFS_TICKDIV) begin
            tick_div_r <= reg_wdata[DIV_W-1:0];
        end
    end

    // Read words, unused bits zero
    // Status is a live view, nothing is latched
    assign ctrl_word = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};

    always_comb begin
        stat_word = '0;
        stat_word[STAT_OUT_A]    = pwm_out_a;
        stat_word[STAT_OUT_B]    = pwm_out_b;
        stat_word[STAT_RED_BUSY] = red_busy;
        stat_word[STAT_FED_BUSY] = fed_busy;
    end

    // Read decode; unmapped offsets answer zero
    always_comb begin
        rd_nxt = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL:    rd_nxt = ctrl_word;
                OFS_RED:     rd_nxt = {6'h00, red_count_r};
                OFS_FED:     rd_nxt = {6'h00, fed_count_r};
                OFS_TICKDIV: rd_nxt = {8'h00, tick_div_r};
                OFS_STATUS:  rd_nxt = stat_word;
                default:     rd_nxt = '0;
            endcase
        end
    end

    // Read data stands for the one cycle after the strobe only
    // Software must catch the word in that cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rd_nxt;
        end
    end

    // Time-base tick from the system clock
    // A lowered divider wraps at once
    tick_divider u_tick (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .div     (tick_div_r),
        .tick    (timebase_tick)
    );

    // Source mux: in_mode bit0 moves rising source to B,
    // bit1 moves falling source to B; all four codes are live
    assign red_src = pick_src(ctrl_r.in_mode[0],
                              pwm_in_a, pwm_in_b);
    assign fed_src = pick_src(ctrl_r.in_mode[1],
                              pwm_in_a, pwm_in_b);

    // A pulse shorter than its delay is lost
    // Rising-edge delay path
    edge_delay #(.RISE(1'b1)) u_red (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (timebase_tick),
        .din     (red_src),
        .count   (red_count_r),
        .dout    (red_y),
        .busy    (red_busy)
    );

    // Falling-edge delay path
    edge_delay #(.RISE(1'b0)) u_fed (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (timebase_tick),
        .din     (fed_src),
        .count   (fed_count_r),
        .dout    (fed_y),
        .busy    (fed_busy)
    );

    // Bypass inputs take one flop so that both routes have equal
    // latency; switching out_mode then makes no stray glitch
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            in_a_d_r <= 1'b0;
            in_b_d_r <= 1'b0;
        end else begin
            in_a_d_r <= pwm_in_a;
            in_b_d_r <= pwm_in_b;
        end
    end

    // Output select and polarity; no combination is blocked
    // Polarity acts only on delayed routes
    always_comb begin
        // Rising path feeds A, falling path feeds B
        out_a_nxt = sel_a ? (red_y ^ pol_a) : in_a_d_r;
        out_b_nxt = sel_b ? (fed_y ^ pol_b) : in_b_d_r;
    end

    // Output flops; mode 0,0 is a plain pass, 0,1 and 1,0 mix
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_out_a <= 1'b0;
            pwm_out_b <= 1'b0;
        end else begin
            pwm_out_a <= out_a_nxt;
            pwm_out_b <= out_b_nxt;
        end
    end

    // The four output checks below need a settled configuration: no write in
    // the last three cycles
    // Three quiet cycles cover the two-clock path
    logic [1:0] quiet_r;                      // Cycles since last write

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_r <= 2'h0;
        end else if (reg_wr) begin
            quiet_r <= 2'h0;
        end else if (quiet_r != 2'h3) begin
            quiet_r <= quiet_r + 2'h1;
        end
    end

    // All checks run on the system clock
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Bypass: two clocks, polarity ignored
    a_bypass_a: assert property (
        (quiet_r == 2'h3 && !sel_a)
        |-> pwm_out_a == $past(pwm_in_a, 2))
        else $error("pwm_out_a not passed through");

    a_bypass_b: assert property (
        (quiet_r == 2'h3 && !sel_b)
        |-> pwm_out_b == $past(pwm_in_b, 2))
        else $error("pwm_out_b not passed through");

    // Zero-count rising path, then polarity
    a_rising_pol: assert property (
        (quiet_r == 2'h3 && sel_a && !ctrl_r.in_mode[0] &&
         red_count_r == CNT_RST)
        |-> pwm_out_a == ($past(pwm_in_a, 2) ^ pol_a))
        else $error("rising path polarity wrong on A");

    // B feeding both paths, falling route
    a_falling_src: assert property (
        (quiet_r == 2'h3 && sel_b && ctrl_r.in_mode == 2'h3 &&
         fed_count_r == CNT_RST)
        |-> pwm_out_b == ($past(pwm_in_b, 2) ^ pol_b))
        else $error("falling path source or polarity wrong");

    // Writes land at the strobe edge
    a_write_red: assert property (
        (reg_wr && reg_addr == OFS_RED)
        |=> red_count_r == $past(wdata_cnt))
        else $error("rising count write lost");

    a_write_fed: assert property (
        (reg_wr && reg_addr == OFS_FED)
        |=> fed_count_r == $past(wdata_cnt))
        else $error("falling count write lost");

    a_write_ctrl: assert property (
        (reg_wr && reg_addr == OFS_CTRL)
        |=> ctrl_r == $past(reg_wdata[CTRL_W-1:0]))
        else $error("control write lost");

    // Status mirrors the output flops
    a_status_pair: assert property (
        (reg_rd && reg_addr == OFS_STATUS)
        |=> reg_rdata[1:0] == {$past(pwm_out_b), $past(pwm_out_a)})
        else $error("status does not show the pair");

    // Control read: one cycle of data, then
    // zero unless another read follows
    sequence s_ctrl_read;
        reg_rd && reg_addr == OFS_CTRL;
    endsequence

    sequence s_ctrl_answer;
        reg_rdata == $past(ctrl_word) ##1
        (reg_rdata == '0 || $past(reg_rd));
    endsequence

    a_read_ctrl: assert property (
        s_ctrl_read |=> s_ctrl_answer)
        else $error("control read back wrong");

endmodule : pwm_deadband_generator

// File: tb/pwm_source_model.sv
// Upstream qualifier model that drives the stage's A and B inputs
`timescale 1ns/1ps
module pwm_source_model (
    input  wire logic clk_sys,   // System clock
    input  wire logic sys_rst,   // Async reset, active high
    input  wire logic want_a,    // Level asked for on A
    input  wire logic want_b,    // Level asked for on B
    output logic      pwm_in_a,  // Qualifier output A
    output logic      pwm_in_b   // Qualifier output B
);
    // Edge logic upstream changes only on clock edges, so outputs are flops
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_in_a <= 1'b0;
            pwm_in_b <= 1'b0;
        end else begin
            pwm_in_a <= want_a;
            pwm_in_b <= want_b;
        end
    end
endmodule : pwm_source_model

// File: tb/pwm_deadband_generator_bench.sv
// Self-checking bench for the dead-band generator stage
`timescale 1ns/1ps
module pwm_deadband_generator_bench;
    import deadband_pkg::*;
    localparam int BASE = 3;             // Model flop plus two stage clocks
    logic              clk_sys   = 1'b0; // 50 ns clock
    logic              sys_rst   = 1'b1; // Reset, held at start
    logic              want_a    = 1'b0; // Requested level A
    logic              want_b    = 1'b0; // Requested level B
    logic              pwm_in_a;         // Stage input A
    logic              pwm_in_b;         // Stage input B
    logic [ADDR_W-1:0] reg_addr  = '0;   // Register offset
    logic [DATA_W-1:0] reg_wdata = '0;   // Write data
    logic              reg_wr    = 1'b0; // Write strobe
    logic              reg_rd    = 1'b0; // Read strobe
    logic [DATA_W-1:0] reg_rdata;        // Read data
    logic              pwm_out_a;        // Output A
    logic              pwm_out_b;        // Output B
    logic [5:0]        cc        = '0;   // Control word in force
    int                nr        = 0;    // Rising count in force
    int                nf        = 0;    // Falling count in force
    int                dv        = 0;    // Divider in force
    int                n_errors  = 0;    // Mismatches
    int                total_checks = 0; // Comparisons
    int                ta;               // Measured latency A
    int                tb;               // Measured latency B

    // Free-running system clock
    always #25 clk_sys = ~clk_sys;

    pwm_source_model src (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .want_a(want_a), .want_b(want_b),
        .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b));

    pwm_deadband_generator uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_out_a(pwm_out_a),
        .pwm_out_b(pwm_out_b));

    // Compare with case equality so unknowns never match
    task automatic check(input string what, input logic [15:0] got,
                         input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Verdict and end of run, shared with the watchdog
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // One-cycle read strobe; data stand only in the following cycle
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // Settled output pair {a,b} for a control word and input levels
    function automatic logic [1:0] ref_pair(input logic [5:0] c,
                                            input logic a, input logic b);
        logic rs;
        logic fs;
        rs = c[4] ? b : a;
        fs = c[5] ? b : a;
        return {c[1] ? rs ^ c[2] : a, c[0] ? fs ^ c[3] : b};
    endfunction : ref_pair

    // Program counts, divider and control, then check the idle pair
    task automatic set_cfg(input logic [5:0] c, input logic [9:0] r,
                           input logic [9:0] f, input logic [7:0] d);
        logic [1:0] p;
        cc = c;
        nr = r;
        nf = f;
        dv = d;
        reg_write(OFS_RED, {6'h00, r});
        reg_write(OFS_FED, {6'h00, f});
        reg_write(OFS_TICKDIV, {8'h00, d});
        reg_write(OFS_CTRL, {10'h000, c});
        repeat (4) @(posedge clk_sys);
        #1;
        p = ref_pair(c, want_a, want_b);
        check("idle_pair", {14'h0, pwm_out_a, pwm_out_b}, {14'h0, p});
    endtask : set_cfg

    // Change inputs, time each output until it reaches its new level
    task automatic step(input logic na, input logic nb,
                        output int la, output int lb);
        logic [1:0] po;
        logic [1:0] pn;
        int         ea;
        int         eb;
        po = ref_pair(cc, want_a, want_b);
        pn = ref_pair(cc, na, nb);
        // Only the own edge type of a path is held back
        ea = (po[1] == pn[1]) ? 1 :
             (cc[1] && (cc[4] ? nb : na)) ? BASE + nr : BASE;
        eb = (po[0] == pn[0]) ? 1 :
             (cc[0] && !(cc[5] ? nb : na)) ? BASE + nf : BASE;
        la = -1;
        lb = -1;
        @(posedge clk_sys);
        want_a <= na;
        want_b <= nb;
        for (int k = 1; k < 1200 && (la < 0 || lb < 0); k++) begin
            @(posedge clk_sys);
            #1;
            if (la < 0 && pwm_out_a === pn[1]) la = k;
            if (lb < 0 && pwm_out_b === pn[0]) lb = k;
        end
        // Exact cycle figures only hold with a tick every clock
        if (dv == 0) begin
            check("time_a", 16'(la), 16'(ea));
            check("time_b", 16'(lb), 16'(eb));
        end
    endtask : step

    // Settled levels for one configuration, then back to idle
    task automatic level(input logic [5:0] c, input logic a, input logic b,
                         input logic xa, input logic xb);
        set_cfg(c, 10'h003, 10'h005, 8'h00);
        step(a, b, ta, tb);
        check("lvl_pair", {14'h0, pwm_out_a, pwm_out_b}, {14'h0, xa, xb});
        step(1'b0, 1'b0, ta, tb);
    endtask : level

    // Reset values, implemented bits, unmapped offset, read data lifetime
    task automatic reg_test();
        logic [15:0] d;
        reg_read(OFS_CTRL, d);
        check("ctrl_rst", d, 16'h0000);
        reg_read(OFS_RED, d);
        check("red_rst", d, 16'h0000);
        reg_read(OFS_FED, d);
        check("fed_rst", d, 16'h0000);
        reg_write(OFS_CTRL, 16'hffff);
        reg_read(OFS_CTRL, d);
        check("ctrl_bits", d, 16'h003f);
        reg_write(OFS_RED, 16'hffff);
        reg_read(OFS_RED, d);
        check("red_bits", d, 16'h03ff);
        reg_write(OFS_FED, 16'hfc00);
        reg_read(OFS_FED, d);
        check("fed_bits", d, 16'h0000);
        @(posedge clk_sys);
        #1;
        check("rdata_gone", reg_rdata, 16'h0000);
        reg_write(8'h40, 16'h1234);
        reg_read(8'h40, d);
        check("unmapped", d, 16'h0000);
        set_cfg(6'h00, 10'h000, 10'h000, 8'h00);
        $display("Test reg_test done");
    endtask : reg_test

    // Every source, apply and polarity combination with rise and fall
    task automatic all_modes();
        for (int c = 0; c < 64; c++) begin
            set_cfg(c[5:0], 10'h003, 10'h005, 8'h00);
            step(1'b1, 1'b0, ta, tb);
            step(1'b1, 1'b1, ta, tb);
            step(1'b0, 1'b1, ta, tb);
            step(1'b0, 1'b0, ta, tb);
        end
        $display("Test all_modes done");
    endtask : all_modes

    // Largest count, zero count, and delay scaled by the tick period
    task automatic count_test();
        logic [15:0] d;
        set_cfg(6'h03, 10'h3ff, 10'h000, 8'h00);
        step(1'b1, 1'b0, ta, tb);
        step(1'b0, 1'b0, ta, tb);
        set_cfg(6'h03, 10'h004, 10'h002, 8'h03);
        step(1'b1, 1'b0, ta, tb);
        check("tick_rise", 16'(ta >= BASE + 12 && ta <= BASE + 17), 16'h1);
        step(1'b0, 1'b0, ta, tb);
        check("tick_fall", 16'(tb >= BASE + 4 && tb <= BASE + 9), 16'h1);
        set_cfg(6'h07, 10'h000, 10'h002, 8'h01);
        reg_read(OFS_TICKDIV, d);
        check("div_read", d, 16'h0001);
        step(1'b1, 1'b0, ta, tb);
        check("zero_red", 16'(ta), 16'(BASE));
        step(1'b0, 1'b0, ta, tb);
        check("tick_half", 16'(tb >= BASE + 3 && tb <= BASE + 4), 16'h1);
        set_cfg(6'h00, 10'h000, 10'h000, 8'h00);
        step(1'b1, 1'b0, ta, tb);
        reg_read(OFS_STATUS, d);
        check("status", d, 16'h0001);
        step(1'b0, 1'b0, ta, tb);
        $display("Test count_test done");
    endtask : count_test

    // Watchdog well beyond the expected run of about 3400 cycles
    initial begin
        #(30000 * 50);
        n_errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        step(1'b1, 1'b0, ta, tb);
        step(1'b0, 1'b0, ta, tb);
        reg_test();
        level(6'h0b, 1'b1, 1'b0, 1'b1, 1'b0);
        level(6'h07, 1'b1, 1'b0, 1'b0, 1'b1);
        level(6'h03, 1'b1, 1'b0, 1'b1, 1'b1);
        level(6'h0f, 1'b1, 1'b0, 1'b0, 1'b0);
        level(6'h01, 1'b1, 1'b0, 1'b1, 1'b1);
        level(6'h02, 1'b0, 1'b1, 1'b0, 1'b1);
        level(6'h0c, 1'b1, 1'b0, 1'b1, 1'b0);
        level(6'h33, 1'b0, 1'b1, 1'b1, 1'b1);
        level(6'h13, 1'b1, 1'b0, 1'b0, 1'b1);
        $display("Test classical_levels done");
        all_modes();
        count_test();
        report_and_stop();
    end
endmodule : pwm_deadband_generator_bench
